// [psh_axil_slave.sv]
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
module psh_axil_slave (
    input  wire logic        aclk,     // System clock
    input  wire logic        aresetn,  // Sync reset, active low
    input  wire logic        ce,       // Clock enable
    input  wire logic [7:0]  awaddr,   // Write address
    input  wire logic        awvalid,  // Write address valid
    output logic             awready,  // Write address ready
    input  wire logic [31:0] wdata,    // Write data
    input  wire logic [3:0]  wstrb,    // Byte strobes
    input  wire logic        wvalid,   // Write data valid
    output logic             wready,   // Write data ready
    output logic [1:0]       bresp,    // Write response
    output logic             bvalid,   // Write response valid
    input  wire logic        bready,   // Write response ready
    input  wire logic [7:0]  araddr,   // Read address
    input  wire logic        arvalid,  // Read address valid
    output logic             arready,  // Read address ready
    output logic [31:0]      rdata,    // Read data
    output logic [1:0]       rresp,    // Read response
    output logic             rvalid,   // Read valid
    input  wire logic        rready,   // Read ready
    output logic             wr_en,    // Register write pulse
    output logic [7:0]       wr_addr,  // Register write address
    output logic [31:0]      wr_data,  // Register write data
    output logic [3:0]       wr_strb,  // Register write strobes
    input  wire logic        wr_err,   // Write address unmapped or read only
    input  wire logic [31:0] rd_data,  // Read data for araddr
    input  wire logic        rd_err    // Read address unmapped
);
    psh_pkg::psh_axil_s r_reg, r_next;

    // Ready terms stall while a response is still owed
    assign awready = ce && !r_reg.aw_have && !r_reg.bvalid;
    assign wready  = ce && !r_reg.w_have && !r_reg.bvalid;
    assign arready = ce && !r_reg.rvalid;
    assign wr_en   = ce && r_reg.aw_have && r_reg.w_have && !r_reg.bvalid;
    assign wr_addr = r_reg.awaddr;
    assign wr_data = r_reg.wdata;
    assign wr_strb = r_reg.wstrb;
    assign bvalid  = r_reg.bvalid;
    assign bresp   = r_reg.bresp;
    assign rvalid  = r_reg.rvalid;
    assign rdata   = r_reg.rdata;
    assign rresp   = r_reg.rresp;

    // Channel capture and response generation
    always_comb begin
        r_next = r_reg;
        if (awvalid && awready) begin
            r_next.aw_have = 1'b1;
            r_next.awaddr  = awaddr;
        end
        if (wvalid && wready) begin
            r_next.w_have = 1'b1;
            r_next.wdata  = wdata;
            r_next.wstrb  = wstrb;
        end
        if (wr_en) begin
            r_next.aw_have = 1'b0;
            r_next.w_have  = 1'b0;
            r_next.bvalid  = 1'b1;
            r_next.bresp   = wr_err ? psh_pkg::RESP_SLVERR
                                    : psh_pkg::RESP_OKAY;
        end
        if (ce && r_reg.bvalid && bready) begin
            r_next.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            r_next.rvalid = 1'b1;
            r_next.rdata  = rd_data;
            r_next.rresp  = rd_err ? psh_pkg::RESP_SLVERR
                                   : psh_pkg::RESP_OKAY;
        end
        if (ce && r_reg.rvalid && rready) begin
            r_next.rvalid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

// [psh_host.sv]
// Host model: AXI4-Lite master for single register cycles
`timescale 1ns/1ps
module psh_host (
    input  wire logic        aclk,    // Clock
    output logic [7:0]       awaddr,  // AW addr
    output logic             awvalid, // AW valid
    input  wire logic        awready, // AW ready
    output logic [31:0]      wdata,   // W data
    output logic [3:0]       wstrb,   // W strobes
    output logic             wvalid,  // W valid
    input  wire logic        wready,  // W ready
    input  wire logic [1:0]  bresp,   // B resp
    input  wire logic        bvalid,  // B valid
    output logic             bready,  // B ready
    output logic [7:0]       araddr,  // AR addr
    output logic             arvalid, // AR valid
    input  wire logic        arready, // AR ready
    input  wire logic [31:0] rdata,   // R data
    input  wire logic [1:0]  rresp,   // R resp
    input  wire logic        rvalid,  // R valid
    output logic             rready   // R ready
);
    // Whole words only, so every strobe stays set
    assign wstrb = 4'hF;
    // Idle bus from time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 48'h0;
    end
    // Each channel is released only at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    // Read: address, then data held until rvalid is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

// [psh_pkg.sv]
// Shared constants and state types for the profile setpoint handshake
package psh_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] TARGET_OFS   = 8'h04;
    localparam logic [7:0] VEL_OFS      = 8'h08;
    localparam logic [7:0] ACC_OFS      = 8'h0C;
    localparam logic [7:0] STATUS_OFS   = 8'h10;
    localparam logic [7:0] ACTUAL_OFS   = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
    // Control word bit positions
    localparam int CTRL_NEW_SP_BIT  = 4;
    localparam int CTRL_CHAIN_BIT   = 5;
    localparam int CTRL_REL_BIT     = 6;
    localparam int CTRL_SINE_BIT    = 8;
    localparam int CTRL_W           = 16;
    // Status word bit positions
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_PEND_BIT    = 1;
    localparam int STAT_ARRIVED_BIT = 10;
    localparam int STAT_ACK_BIT     = 12;
    // Interrupt bits
    localparam int IRQ_TAKEN_BIT    = 0;
    localparam int IRQ_ARRIVED_BIT  = 1;
    localparam int IRQ_IGNORED_BIT  = 2;
    localparam int IRQ_W            = 3;
    // Reset values
    localparam logic [31:0] VEL_RST = 32'h0000000A;
    localparam logic [31:0] ACC_RST = 32'h00000000;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Bus slave state
    typedef struct packed {
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } psh_axil_s;

    // Ramp generator state
    typedef struct packed {
        logic signed [31:0] pos;
        logic [31:0]        speed;
        logic [31:0]        rdist;
    } psh_ramp_s;

    // Top-level state
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [31:0]       target;
        logic [31:0]       vel;
        logic [31:0]       acc;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic              req_prev;
        logic              ack;
        logic              pend_edge;
        logic [31:0]       goal;
        logic [31:0]       last_goal;
        logic [31:0]       next_goal;
        logic              next_valid;
        logic              moving;
        logic              reached;
        logic              chain_lat;
    } psh_top_s;
endpackage

// [psh_ramp.sv]
// Trapezoidal position ramp with optional speed hold at the goal
`timescale 1ns/1ps
module psh_ramp (
    input  wire logic        aclk,     // System clock
    input  wire logic        aresetn,  // Sync reset, active low
    input  wire logic        ce,       // Clock enable
    input  wire logic        active,   // Move in progress
    input  wire logic        keep,     // Hold speed through the goal
    input  wire logic [31:0] goal,     // Absolute goal position
    input  wire logic [31:0] vmax,     // Profile speed per tick
    input  wire logic [31:0] acc,      // Speed change per tick
    output logic             arrive,   // Goal reached this tick
    output logic [31:0]      pos,      // Actual position
    output logic [31:0]      speed     // Actual speed magnitude
);
    psh_pkg::psh_ramp_s r_reg, r_next;
    logic signed [32:0] diff;
    logic [32:0]        mag;
    logic [31:0]        step;

    assign diff   = $signed({goal[31], goal}) -
                    $signed({r_reg.pos[31], r_reg.pos});
    assign mag    = diff[32] ? 33'(-diff) : 33'(diff);
    assign step   = (acc == 32'h00000000) ? 32'h00000001 : acc;
    assign arrive = ce && active && (mag <= {1'b0, r_reg.speed});
    assign pos    = r_reg.pos;
    assign speed  = r_reg.speed;

    // Braking starts once the rest fits in the distance spent accelerating
    always_comb begin
        r_next = r_reg;
        if (ce && active) begin
            if (arrive) begin
                r_next.pos = goal;
                if (!keep) begin
                    r_next.speed = 32'h00000000;
                    r_next.rdist = 32'h00000000;
                end
            end else begin
                if (!keep && mag <= 33'(r_reg.rdist) + 33'(r_reg.speed)) begin
                    r_next.speed = (r_reg.speed > step) ?
                        r_reg.speed - step : 32'h00000001;
                    r_next.rdist = (r_reg.rdist > r_reg.speed) ?
                        r_reg.rdist - r_reg.speed : 32'h00000000;
                end else if (r_reg.speed < vmax) begin
                    r_next.speed = (vmax - r_reg.speed > step) ?
                        r_reg.speed + step : vmax;
                    r_next.rdist = r_reg.rdist + r_next.speed;
                end
                r_next.pos = diff[32] ? r_reg.pos - $signed(r_next.speed)
                                      : r_reg.pos + $signed(r_next.speed);
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

// [psh_top.sv]
// Profile position setpoint intake, handshake and sequencing
// Behaviour
// [RQ1] Chain select low at move start means single goals, high means chained.
// [RQ2] With chain select low, one goal is run at a time, then a stop.
// [RQ3] Host writes the target first, then raises the new-setpoint bit.
// [RQ4] Once the setpoint is buffered, the acknowledge status bit goes high.
// [RQ5] Host drops the new-setpoint bit after seeing the acknowledge.
// [RQ6] After the host drops its request, the acknowledge falls again.
// [RQ7] Single mode brakes to zero at each goal before the next move.
// [RQ8] Chain mode keeps speed at the goal and runs on to the buffered one.
// [RQ9] Chaining without a stop only applies with trapezoidal ramps.
// [RQ10] A rising edge of the new-setpoint bit offers a new setpoint.
// [RQ11] Host raises the request only while the acknowledge is low.
// [RQ12] A further setpoint may be queued while one is still running.
// [RQ13] Relative bit set: target is added to the last goal.
// [RQ14] Other relative kinds are configured by the host beforehand.
// [RQ15] In single mode the arrived status bit is set at the goal.
// [RQ16] A rising edge while acknowledge is high is dropped, nothing stored.
`timescale 1ns/1ps
module psh_top (
    input  wire logic        aclk,     // System clock, 200 MHz
    input  wire logic        aresetn,  // Sync reset, active low
    input  wire logic        ce,       // Clock enable, freezes all state
    input  wire logic [7:0]  awaddr,   // Write address
    input  wire logic        awvalid,  // Write address valid
    output logic             awready,  // Write address ready
    input  wire logic [31:0] wdata,    // Write data
    input  wire logic [3:0]  wstrb,    // Byte strobes
    input  wire logic        wvalid,   // Write data valid
    output logic             wready,   // Write data ready
    output logic [1:0]       bresp,    // Write response
    output logic             bvalid,   // Write response valid
    input  wire logic        bready,   // Write response ready
    input  wire logic [7:0]  araddr,   // Read address
    input  wire logic        arvalid,  // Read address valid
    output logic             arready,  // Read address ready
    output logic [31:0]      rdata,    // Read data
    output logic [1:0]       rresp,    // Read response
    output logic             rvalid,   // Read valid
    input  wire logic        rready,   // Read ready
    output logic             irq,      // Level interrupt, active high
    output logic [31:0]      act_pos,  // Actual position
    output logic [31:0]      act_speed // Actual speed magnitude
);
    psh_pkg::psh_top_s r_reg, r_next;

    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic [31:0] rd_data;
    logic        rd_err;
    logic        arrive;
    logic        keep;
    logic        req_lvl;
    logic        req_edge;
    logic        take;
    logic        ignore;
    logic        sine_ramp;
    logic [31:0] new_goal;
    logic [15:0] status_word;
    localparam int IRQ_W_L = psh_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_evt;


    psh_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    psh_ramp u_ramp (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .active  (r_reg.moving),
        .keep    (keep),
        .goal    (r_reg.goal),
        .vmax    (r_reg.vel),
        .acc     (r_reg.acc),
        .arrive  (arrive),
        .pos     (act_pos),
        .speed   (act_speed)
    );

    // Handshake decode
    assign req_lvl   = r_reg.ctrl[psh_pkg::CTRL_NEW_SP_BIT];
    assign sine_ramp = r_reg.ctrl[psh_pkg::CTRL_SINE_BIT];
    assign req_edge  = ce && req_lvl && !r_reg.req_prev; // [RQ10]
    // Rising edge seen under a high acknowledge is dropped
    assign ignore    = req_edge && r_reg.ack; // [RQ16]
    // A second pending goal waits until the queue slot frees
    assign take      = ce && req_lvl && !r_reg.ack && !r_reg.next_valid &&
                       ((req_edge && !r_reg.ack) || r_reg.pend_edge);
    // Relative goals stack on the newest accepted goal
    assign new_goal  = r_reg.ctrl[psh_pkg::CTRL_REL_BIT] ?
                       r_reg.last_goal + r_reg.target : r_reg.target; // [RQ13]
    // Hold speed only in chain mode, trapezoid ramps, next goal ready
    assign keep      = r_reg.moving && r_reg.chain_lat && !sine_ramp &&
                       r_reg.next_valid; // [RQ8] [RQ9]

    // Status word
    always_comb begin
        status_word = 16'h0000;
        status_word[psh_pkg::STAT_BUSY_BIT]    = r_reg.moving;
        status_word[psh_pkg::STAT_PEND_BIT]    = r_reg.next_valid;
        status_word[psh_pkg::STAT_ARRIVED_BIT] = r_reg.reached;
        status_word[psh_pkg::STAT_ACK_BIT]     = r_reg.ack;
    end

    // Interrupt events
    always_comb begin
        irq_evt = '0;
        irq_evt[psh_pkg::IRQ_TAKEN_BIT]   = take;
        irq_evt[psh_pkg::IRQ_ARRIVED_BIT] = arrive && !keep;
        irq_evt[psh_pkg::IRQ_IGNORED_BIT] = ignore;
    end
    assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

    // Read mux and address checks
    always_comb begin
        rd_err  = 1'b0;
        rd_data = 32'h00000000;
        unique case (araddr)
            psh_pkg::CTRL_OFS:     rd_data = 32'(r_reg.ctrl);
            psh_pkg::TARGET_OFS:   rd_data = r_reg.target;
            psh_pkg::VEL_OFS:      rd_data = r_reg.vel;
            psh_pkg::ACC_OFS:      rd_data = r_reg.acc;
            psh_pkg::STATUS_OFS:   rd_data = 32'(status_word);
            psh_pkg::ACTUAL_OFS:   rd_data = act_pos;
            psh_pkg::IRQ_STAT_OFS: rd_data = 32'(r_reg.irq_stat);
            psh_pkg::IRQ_MASK_OFS: rd_data = 32'(r_reg.irq_mask);
            default:               rd_err  = 1'b1;
        endcase
    end
    // Status and actual position are read only, writes refused
    assign wr_err = !(wr_addr == psh_pkg::CTRL_OFS ||
                      wr_addr == psh_pkg::TARGET_OFS ||
                      wr_addr == psh_pkg::VEL_OFS ||
                      wr_addr == psh_pkg::ACC_OFS ||
                      wr_addr == psh_pkg::IRQ_STAT_OFS ||
                      wr_addr == psh_pkg::IRQ_MASK_OFS);

    // Register writes, handshake and goal sequencing
    always_comb begin
        r_next = r_reg;
        if (ce) begin
            r_next.req_prev = req_lvl;
            if (wr_en) begin
                for (int b = 0; b < 4; b++) begin
                    if (wr_strb[b]) begin
                        unique case (wr_addr)
                            psh_pkg::CTRL_OFS: begin
                                if (b < 2) begin
                                    r_next.ctrl[b*8 +: 8] = wr_data[b*8 +: 8];
                                end
                            end
                            psh_pkg::TARGET_OFS:
                                r_next.target[b*8 +: 8] = wr_data[b*8 +: 8];
                            psh_pkg::VEL_OFS:
                                r_next.vel[b*8 +: 8] = wr_data[b*8 +: 8];
                            psh_pkg::ACC_OFS:
                                r_next.acc[b*8 +: 8] = wr_data[b*8 +: 8];
                            psh_pkg::IRQ_MASK_OFS: begin
                                if (b == 0) begin
                                    r_next.irq_mask = wr_data[IRQ_W_L-1:0];
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
            // Write one clears, a new event in the same cycle wins
            if (wr_en && wr_addr == psh_pkg::IRQ_STAT_OFS && wr_strb[0]) begin
                r_next.irq_stat = r_reg.irq_stat & ~wr_data[IRQ_W_L-1:0];
            end
            r_next.irq_stat = r_next.irq_stat | irq_evt;
            // Edge seen while queue full is held until the slot frees or the request drops
            if (req_edge && !r_reg.ack && r_reg.next_valid) begin
                r_next.pend_edge = 1'b1;
            end
            if (take || !req_lvl) begin
                r_next.pend_edge = 1'b0;
            end
            // Acknowledge falls once the host has let go
            if (r_reg.ack && !req_lvl) begin
                r_next.ack = 1'b0; // [RQ6]
            end
            // Goal reached
            if (arrive) begin
                if (keep) begin
                    r_next.goal       = r_reg.next_goal; // [RQ8]
                    r_next.next_valid = 1'b0;
                end else begin
                    r_next.moving  = 1'b0; // [RQ7]
                    r_next.reached = 1'b1; // [RQ15]
                end
            end else if (!r_reg.moving && r_reg.next_valid) begin
                // Without a chained hold, a queued goal starts from standstill
                r_next.goal       = r_reg.next_goal; // [RQ7]
                r_next.next_valid = 1'b0;
                r_next.moving     = 1'b1;
                r_next.reached    = 1'b0;
                r_next.chain_lat  = r_reg.ctrl[psh_pkg::CTRL_CHAIN_BIT];
            end
            // Accept and buffer a new setpoint
            if (take) begin
                r_next.ack       = 1'b1; // [RQ4]
                r_next.last_goal = new_goal;
                if (!r_reg.moving && !r_reg.next_valid) begin
                    r_next.goal      = new_goal;
                    r_next.moving    = 1'b1;
                    r_next.reached   = 1'b0;
                    // Mode follows the chain bit as the run begins
                    r_next.chain_lat =
                        r_reg.ctrl[psh_pkg::CTRL_CHAIN_BIT]; // [RQ1] [RQ2]
                end else begin
                    r_next.next_goal  = new_goal; // [RQ12]
                    r_next.next_valid = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg          <= '0;
            r_reg.vel      <= psh_pkg::VEL_RST;
            r_reg.acc      <= psh_pkg::ACC_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ack_on_take;
        take |=> r_reg.ack && r_reg.last_goal == $past(new_goal);
    endproperty
    a_ack_on_take: assert property (p_ack_on_take) // [RQ4]
        else $error("acknowledge not raised after take");

    property p_ack_release;
        ce && r_reg.ack && !req_lvl |=> !r_reg.ack;
    endproperty
    a_ack_release: assert property (p_ack_release) // [RQ6]
        else $error("acknowledge stuck after request release");

    property p_ignore;
        ignore |=> $stable(r_reg.next_goal) && $stable(r_reg.last_goal);
    endproperty
    a_ignore: assert property (p_ignore) // [RQ16]
        else $error("setpoint stored under high acknowledge");

    property p_take_cause;
        take |-> req_lvl && (!$past(req_lvl) || r_reg.pend_edge);
    endproperty
    a_take_cause: assert property (p_take_cause) // [RQ10]
        else $error("setpoint taken without a rising request");

    property p_single_stop;
        arrive && !keep |=> act_speed == 32'h00000000 && !r_reg.moving;
    endproperty
    a_single_stop: assert property (p_single_stop) // [RQ7]
        else $error("single goal not brought to standstill");

    property p_chain_keep;
        arrive && keep |=> r_reg.moving &&
            r_reg.goal == $past(r_reg.next_goal) &&
            act_speed == $past(act_speed);
    endproperty
    a_chain_keep: assert property (p_chain_keep) // [RQ8]
        else $error("chained goal lost speed or goal");

    property p_sine_no_chain;
        arrive && sine_ramp |=> act_speed == 32'h00000000;
    endproperty
    a_sine_no_chain: assert property (p_sine_no_chain) // [RQ9]
        else $error("chaining with non trapezoidal ramp");

    property p_reached;
        arrive && !keep |=> r_reg.reached && act_pos == $past(r_reg.goal);
    endproperty
    a_reached: assert property (p_reached) // [RQ15]
        else $error("arrived flag not set at goal");

    property p_single_mode;
        r_reg.moving && !r_reg.chain_lat |-> !keep;
    endproperty
    a_single_mode: assert property (p_single_mode) // [RQ1] [RQ2]
        else $error("single mode held speed through a goal");

    property p_queue;
        take && r_reg.moving |=> r_reg.next_valid;
    endproperty
    a_queue: assert property (p_queue) // [RQ12]
        else $error("setpoint not queued during a move");
endmodule

// [psh_top_tb.sv]
// Self-checking bench for the setpoint handshake block
`timescale 1ns/1ps
module psh_top_tb;
    localparam logic [31:0] ACK = 32'h1 << psh_pkg::STAT_ACK_BIT;
    localparam logic [31:0] ARR = 32'h1 << psh_pkg::STAT_ARRIVED_BIT;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, act_pos, act_speed, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #2.5 aclk = ~aclk;
    psh_top u_dut (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .irq, .act_pos, .act_speed);
    psh_host u_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Status polling is bounded so a stuck flag cannot hang the run
    task automatic poll(input logic [31:0] m, e);
        for (int i = 0; i < 300; i++) begin
            u_host.rd(psh_pkg::STATUS_OFS, rv, rsp);
            if ((rv & m) === e) break;
        end
        chk(rv & m, e);
    endtask
    task automatic sp(input logic [31:0] t, c);
        u_host.wr(psh_pkg::TARGET_OFS, t, rsp);
        u_host.wr(psh_pkg::CTRL_OFS, c | 32'h10, rsp);
        poll(ACK, ACK);
        u_host.wr(psh_pkg::CTRL_OFS, c, rsp);
        poll(ACK, 32'h0);
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence: reset, bus errors, single, relative, chained
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        u_host.rd(psh_pkg::VEL_OFS, rv, rsp);
        chk(rv, psh_pkg::VEL_RST);
        u_host.rd(8'h20, rv, rsp);
        chk(rsp, psh_pkg::RESP_SLVERR);
        u_host.wr(psh_pkg::STATUS_OFS, 32'hFFFF, rsp);
        chk(rsp, psh_pkg::RESP_SLVERR);
        u_host.wr(psh_pkg::IRQ_MASK_OFS, 32'h2, rsp);
        sp(32'h40, 32'h0);
        poll(ARR | 32'h1, ARR);
        chk(act_pos, 32'h40);
        chk(act_speed, 32'h0);
        chk(irq, 1'b1);
        u_host.wr(psh_pkg::IRQ_STAT_OFS, 32'h7, rsp);
        u_host.rd(psh_pkg::IRQ_STAT_OFS, rv, rsp);
        chk(rv, 32'h0);
        chk(irq, 1'b0);
        sp(32'h10, 32'h40);
        poll(ARR | 32'h1, ARR);
        chk(act_pos, 32'h50);
        sp(32'h400, 32'h20);
        sp(32'h800, 32'h20);
        poll(ARR | 32'h1, ARR);
        chk(act_pos, 32'h800);
        // Sine ramp with chain select: each goal ends at standstill
        sp(32'h900, 32'h120);
        sp(32'h980, 32'h120);
        poll(ARR | 32'h3, ARR);
        chk(act_pos, 32'h980);
        chk(act_speed, 32'h0);
        wrap_up();
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #100us;
        n_mismatch++;
        wrap_up();
    end
endmodule
